//--- rfid_consts.vh
`ifndef RFID_CONSTS_VH
`define RFID_CONSTS_VH
`define OFF_CTRL       8'h00
`define OFF_STATUS     8'h04
`define OFF_LOCKS      8'h08
`define OFF_BLK_WIN    3'h1
`define CTRL_FIELD_BIT 0
`define ST_ERR_BIT     7
`define CFG_MKEY_HI    31
`define CFG_MKEY_LO    28
`define CFG_AOR        9
`define CFG_OTP        8
`define CFG_MAXB_HI    7
`define CFG_MAXB_LO    5
`define CFG_PWD        4
`define CFG_PORD       0
`define MKEY_NO_TEST   4'h6
`define OP_RESET       2'h0
`define OP_TEST        2'h1
`define OP_WAKE        2'h2
`define LEN_OPC        7'h02
`define LEN_DA         7'h06
`define LEN_WAKE       7'h22
`define LEN_STD        7'h26
`define LEN_PWD        7'h46
`define LEN_MAX        7'h47
`define D0_MIN         7'h10
`define D0_MAX         7'h1F
`define D1_MIN         7'h30
`define D1_MAX         7'h3F
`define END_FC         7'h40
`define INIT_FC        14'h00C0
`define POR_DLY_FC_DEF 8190
`define PROG_TIME_NS   5600000
`define CLK_NS         5
`define PROG_CLKS_DEF  (`PROG_TIME_NS / `CLK_NS)
`define PROG_DLY       4'h3
`endif

//--- gap_bit_decoder.v
`timescale 1ns/1ps
`include "rfid_consts.vh"
module gap_bit_decoder (
   input  wire pclk,
   input  wire presetn,
   input  wire fc_tick,
   input  wire gap_in,
   output reg  frame_r,
   output reg  bit_stb_r,
   output reg  bit_val_r,
   output reg  bad_iv_r,
   output reg  wr_end_r
);
   reg       gap_d_r;
   reg [6:0] iv_r;
   wire      gap_start = gap_in & ~gap_d_r;

   // intervals are measured gap start to gap start, in field clocks
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_d_r   <= 1'b0;
         iv_r      <= 7'h00;
         frame_r   <= 1'b0;
         bit_stb_r <= 1'b0;
         bit_val_r <= 1'b0;
         bad_iv_r  <= 1'b0;
         wr_end_r  <= 1'b0;
      end else begin
         gap_d_r   <= gap_in;
         bit_stb_r <= 1'b0;
         bad_iv_r  <= 1'b0;
         wr_end_r  <= 1'b0;
         if (gap_start) begin
            iv_r    <= 7'h00;
            frame_r <= 1'b1;
            if (frame_r) begin
               if (iv_r >= `D0_MIN && iv_r <= `D0_MAX) begin
                  bit_stb_r <= 1'b1;
                  bit_val_r <= 1'b0;
               end else if (iv_r >= `D1_MIN && iv_r <= `D1_MAX) begin
                  bit_stb_r <= 1'b1;
                  bit_val_r <= 1'b1;
               end else begin
                  bad_iv_r <= 1'b1;
               end
            end
         end else if (fc_tick && frame_r) begin
            if (iv_r == `END_FC) begin
               frame_r  <= 1'b0;
               wr_end_r <= 1'b1;
            end else begin
               iv_r <= iv_r + 7'h01;
            end
         end
      end
   end
endmodule

//--- prog_sequencer.v
`timescale 1ns/1ps
module prog_sequencer #(
   parameter [20:0] STEP_CLKS = 21'd560000
) (
   input  wire pclk,
   input  wire presetn,
   input  wire start,
   input  wire erase_ok,
   input  wire write_ok,
   output reg  erase_stb_r,
   output reg  write_stb_r,
   output reg  done_ok_r,
   output reg  done_fail_r,
   output reg  busy_r
);
   localparam [4:0] S_IDLE = 5'h01;
   localparam [4:0] S_ERAS = 5'h02;
   localparam [4:0] S_EVFY = 5'h04;
   localparam [4:0] S_PROG = 5'h08;
   localparam [4:0] S_WVFY = 5'h10;
   reg [4:0]  st_r;
   reg [20:0] tmr_r;
   wire       tmr_end = (tmr_r == 21'h000001);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r        <= S_IDLE;
         tmr_r       <= 21'h000000;
         erase_stb_r <= 1'b0;
         write_stb_r <= 1'b0;
         done_ok_r   <= 1'b0;
         done_fail_r <= 1'b0;
         busy_r      <= 1'b0;
      end else begin
         erase_stb_r <= 1'b0;
         write_stb_r <= 1'b0;
         done_ok_r   <= 1'b0;
         done_fail_r <= 1'b0;
         if (tmr_r != 21'h000000)
            tmr_r <= tmr_r - 21'h000001;
         case (st_r)
            S_IDLE: begin
               if (start) begin
                  st_r        <= S_ERAS;
                  erase_stb_r <= 1'b1;
                  tmr_r       <= STEP_CLKS;
                  busy_r      <= 1'b1;
               end
            end
            S_ERAS: begin
               if (tmr_end)
                  st_r <= S_EVFY;
            end
            S_EVFY: begin
               if (erase_ok) begin
                  st_r        <= S_PROG;
                  write_stb_r <= 1'b1;
                  tmr_r       <= STEP_CLKS;
               end else begin
                  st_r        <= S_IDLE;
                  done_fail_r <= 1'b1;
                  busy_r      <= 1'b0;
               end
            end
            S_PROG: begin
               if (tmr_end)
                  st_r <= S_WVFY;
            end
            S_WVFY: begin
               st_r        <= S_IDLE;
               busy_r      <= 1'b0;
               done_ok_r   <= write_ok;
               done_fail_r <= ~write_ok;
            end
            default: begin
               st_r   <= S_IDLE;
               busy_r <= 1'b0;
            end
         endcase
      end
   end
endmodule

//--- rfid_tag_command_decoder.v
`timescale 1ns/1ps
`include "rfid_consts.vh"
module rfid_tag_command_decoder #(
   parameter PROG_CLKS  = `PROG_CLKS_DEF,
   parameter POR_DLY_FC = `POR_DLY_FC_DEF
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        fc_tick,
   input  wire        gap_in,
   input  wire        tx_tick,
   input  wire        nvm_fault,
   output reg         mod_en_r,
   output reg         tx_data_r,
   output reg         prog_busy_r
);
   localparam [4:0]  M_INIT = 5'h01;
   localparam [4:0]  M_REG  = 5'h02;
   localparam [4:0]  M_BLK  = 5'h04;
   localparam [4:0]  M_PROG = 5'h08;
   localparam [4:0]  M_MUTE = 5'h10;
   localparam [20:0] STEP   = PROG_CLKS[21:1];
   localparam [13:0] PORD   = POR_DLY_FC[13:0];

   reg  [32:0] mem_r [0:7];
   reg  [4:0]  mode_r;
   reg         page_r;
   reg         active_r;
   reg         err_r;
   reg         vfail_r;
   reg         ctrl_r;
   reg  [13:0] init_r;
   reg  [6:0]  cnt_r;
   reg  [6:0]  last_cnt_r;
   reg  [69:0] sh_r;
   reg  [1:0]  op_r;
   reg         bad_r;
   reg  [2:0]  tgt_r;
   reg  [31:0] tgt_dat_r;
   reg         tgt_lck_r;
   reg  [3:0]  dly_r;
   reg         start_r;
   reg  [2:0]  tx_blk_r;
   reg  [4:0]  tx_pos_r;
   reg         field_d_r;

   wire        frame;
   wire        bit_stb;
   wire        bit_val;
   wire        bad_iv;
   wire        wr_end;
   wire        erase_stb;
   wire        write_stb;
   wire        done_ok;
   wire        done_fail;
   wire        seq_busy;

   wire [31:0] cfg    = mem_r[0][31:0];
   wire        pwd_en = cfg[`CFG_PWD];
   wire        aor_en = cfg[`CFG_AOR];
   wire        otp    = cfg[`CFG_OTP];
   wire [2:0]  maxb   = cfg[`CFG_MAXB_HI:`CFG_MAXB_LO];
   wire [3:0]  mkey   = cfg[`CFG_MKEY_HI:`CFG_MKEY_LO];
   wire        mk_frz = mem_r[0][32] | otp;

   gap_bit_decoder u_dec (
      .pclk      (pclk),
      .presetn   (presetn),
      .fc_tick   (fc_tick),
      .gap_in    (gap_in),
      .frame_r   (frame),
      .bit_stb_r (bit_stb),
      .bit_val_r (bit_val),
      .bad_iv_r  (bad_iv),
      .wr_end_r  (wr_end)
   );

   // programming check reads back the flop image of the target block
   wire [32:0] tgt_word = mem_r[tgt_r];
   wire        ers_ok   = (tgt_word == 33'h000000000) & ~nvm_fault;
   wire        wrt_ok   = (tgt_word == {tgt_lck_r, tgt_dat_r}) & ~nvm_fault;

   prog_sequencer #(
      .STEP_CLKS (STEP)
   ) u_seq (
      .pclk        (pclk),
      .presetn     (presetn),
      .start       (start_r),
      .erase_ok    (ers_ok),
      .write_ok    (wrt_ok),
      .erase_stb_r (erase_stb),
      .write_stb_r (write_stb),
      .done_ok_r   (done_ok),
      .done_fail_r (done_fail),
      .busy_r      (seq_busy)
   );

   // APB: one access cycle, read data latched in the setup cycle
   wire       win_hit = (paddr[7:5] == `OFF_BLK_WIN) & (paddr[1:0] == 2'h0);
   wire       hit     = win_hit | (paddr == `OFF_CTRL) | (paddr == `OFF_STATUS)
                        | (paddr == `OFF_LOCKS);
   wire       apb_wr  = psel & penable & pready & pwrite & hit;
   wire [2:0] win_idx = paddr[4:2];
   wire [7:0] locks;
   reg  [31:0] rd_mux;

   always @* begin
      rd_mux = 32'h00000000;
      if (win_hit)
         rd_mux = mem_r[win_idx][31:0];
      else if (paddr == `OFF_CTRL)
         rd_mux = {31'h00000000, ctrl_r};
      else if (paddr == `OFF_STATUS)
         rd_mux = {16'h0000, vfail_r, last_cnt_r, err_r, active_r, page_r, mode_r};
      else if (paddr == `OFF_LOCKS)
         rd_mux = {24'h000000, locks};
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         ctrl_r  <= 1'b1;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         if (psel & ~penable) begin
            pready  <= 1'b1;
            pslverr <= ~hit;
            prdata  <= rd_mux;
         end
         if (apb_wr && paddr == `OFF_CTRL)
            ctrl_r <= pwdata[`CTRL_FIELD_BIT];
      end
   end

   // block storage: the erase and write strobes win over APB writes to a block only in their own cycle
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_blk
         assign locks[gi] = mem_r[gi][32];
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               mem_r[gi] <= 33'h000000000;
            end else if (erase_stb && tgt_r == gi) begin
               mem_r[gi] <= 33'h000000000;
            end else if (write_stb && tgt_r == gi) begin
               mem_r[gi] <= {tgt_lck_r, tgt_dat_r};
            end else if (apb_wr && win_hit && win_idx == gi) begin
               mem_r[gi][31:0] <= pwdata;
            end else if (apb_wr && paddr == `OFF_LOCKS) begin
               mem_r[gi][32] <= pwdata[gi];
            end
         end
      end
   endgenerate

   // command classification at frame end
   wire       pg     = op_r[0];
   wire       pgop   = op_r[1];
   wire       z_bit  = ~sh_r[3];
   wire [2:0] c_addr = sh_r[2:0];
   wire       c_lock = sh_r[35];
   wire [31:0] c_dat = sh_r[34:3];
   wire [31:0] pw_rx = (cnt_r == `LEN_PWD) ? sh_r[67:36] :
                       (cnt_r == `LEN_STD) ? sh_r[35:4] : sh_r[31:0];
   wire       pw_ok  = (pw_rx == mem_r[7][31:0]);
   wire       c_rst  = (cnt_r == `LEN_OPC) & (op_r == `OP_RESET);
   wire       c_page = (cnt_r == `LEN_OPC) & pgop;
   wire       c_test = (cnt_r == `LEN_STD) & (op_r == `OP_TEST);
   wire       c_da0  = pgop & ~pwd_en & (cnt_r == `LEN_DA) & z_bit;
   wire       c_wr0  = pgop & ~pwd_en & (cnt_r == `LEN_STD);
   wire       c_wr1  = pgop & pwd_en & (cnt_r == `LEN_PWD);
   wire       c_da1  = pgop & pwd_en & (cnt_r == `LEN_STD) & z_bit;
   wire       c_wake = (op_r == `OP_WAKE) & pwd_en & aor_en & (cnt_r == `LEN_WAKE);
   wire       c_pw   = c_wr1 | c_da1 | c_wake;
   wire       c_ok   = ~bad_r & (c_rst | c_page | c_test | c_da0 | c_wr0
                       | ((c_wr1 | c_da1 | c_wake) & pw_ok));
   wire       c_wr   = c_wr0 | c_wr1;
   wire       c_lckd = mem_r[c_addr][32] | otp | pg;
   wire [2:0] rd_one = (maxb == 3'h0) ? 3'h0 : 3'h1;
   wire       run    = (mode_r == M_INIT) | (mode_r == M_PROG);
   // page 1 holds block 0 at address 0 and zeros elsewhere
   wire [31:0] cur_word = (!page_r) ? mem_r[tx_blk_r][31:0] :
                          (tx_blk_r == 3'h0) ? mem_r[0][31:0] : 32'h00000000;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r      <= 7'h00;
         last_cnt_r <= 7'h00;
         sh_r       <= 70'h0;
         op_r       <= 2'h0;
         bad_r      <= 1'b0;
      end else if (wr_end) begin
         last_cnt_r <= cnt_r;
         cnt_r      <= 7'h00;
         bad_r      <= 1'b0;
      end else begin
         if (bit_stb) begin
            sh_r <= {sh_r[68:0], bit_val};
            if (cnt_r == 7'h00)
               op_r[1] <= bit_val;
            if (cnt_r == 7'h01)
               op_r[0] <= bit_val;
            if (cnt_r != `LEN_MAX)
               cnt_r <= cnt_r + 7'h01;
         end
         if (bad_iv)
            bad_r <= 1'b1;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r    <= M_INIT;
         init_r    <= `INIT_FC;
         page_r    <= 1'b0;
         active_r  <= 1'b0;
         err_r     <= 1'b0;
         vfail_r   <= 1'b0;
         tgt_r     <= 3'h0;
         tgt_dat_r <= 32'h00000000;
         tgt_lck_r <= 1'b0;
         dly_r     <= 4'h0;
         start_r   <= 1'b0;
         tx_blk_r  <= 3'h1;
         tx_pos_r  <= 5'h00;
         tx_data_r <= 1'b0;
         field_d_r <= 1'b1;
      end else begin
         start_r   <= 1'b0;
         field_d_r <= ctrl_r;
         if (field_d_r & ~ctrl_r)
            active_r <= 1'b0;
         if (apb_wr && paddr == `OFF_STATUS && pwdata[`ST_ERR_BIT])
            err_r <= 1'b0;
         if (dly_r != 4'h0) begin
            dly_r <= dly_r - 4'h1;
            if (dly_r == 4'h1)
               start_r <= 1'b1;
         end
         case (mode_r)
            M_INIT: begin
               if (gap_in) begin
                  init_r <= `INIT_FC + (cfg[`CFG_PORD] ? PORD : 14'h0000);
               end else if (fc_tick) begin
                  if (init_r == 14'h0001) begin
                     mode_r   <= M_REG;
                     tx_blk_r <= rd_one;
                     tx_pos_r <= 5'h00;
                  end else begin
                     init_r <= init_r - 14'h0001;
                  end
               end
            end
            M_PROG: begin
               if (done_ok) begin
                  mode_r   <= M_BLK;
                  tx_blk_r <= tgt_r;
                  tx_pos_r <= 5'h00;
               end else if (done_fail) begin
                  mode_r  <= M_MUTE;
                  vfail_r <= 1'b1;
               end
            end
            M_REG, M_BLK: begin
               if (tx_tick) begin
                  tx_data_r <= cur_word[5'h1F - tx_pos_r];
                  tx_pos_r  <= tx_pos_r + 5'h01;
                  if (tx_pos_r == 5'h1F && mode_r == M_REG)
                     tx_blk_r <= (tx_blk_r >= maxb) ? rd_one : tx_blk_r + 3'h1;
               end
            end
            M_MUTE: begin
               // only on a bit boundary, so the line never moves between ticks
               if (tx_tick)
                  tx_data_r <= 1'b0;
            end
            default: begin
               mode_r <= M_REG;
            end
         endcase
         // a new frame ends every mode except init and a running cycle
         if (wr_end && !run) begin
            vfail_r  <= 1'b0;
            tx_pos_r <= 5'h00;
            if (c_pw & ~pw_ok)
               active_r <= 1'b0;
            if (!c_ok) begin
               err_r    <= 1'b1;
               mode_r   <= M_REG;
               tx_blk_r <= rd_one;
               if (pgop && (cnt_r != `LEN_WAKE || pw_ok))
                  page_r <= pg;
            end else if (c_rst) begin
               mode_r   <= M_INIT;
               init_r   <= `INIT_FC;
               active_r <= 1'b0;
               page_r   <= 1'b0;
            end else if (c_page) begin
               mode_r   <= M_REG;
               page_r   <= pg;
               tx_blk_r <= rd_one;
            end else if (c_wake) begin
               active_r <= 1'b1;
               mode_r   <= M_REG;
               tx_blk_r <= rd_one;
            end else if (c_test) begin
               if (mkey != `MKEY_NO_TEST) begin
                  mode_r    <= M_PROG;
                  dly_r     <= `PROG_DLY;
                  tgt_r     <= c_addr;
                  tgt_lck_r <= c_lock;
                  tgt_dat_r <= c_dat;
                  if (c_addr == 3'h0 && mk_frz)
                     tgt_dat_r[`CFG_MKEY_HI:`CFG_MKEY_LO] <= mkey;
               end
            end else if (c_wr && !c_lckd) begin
               mode_r    <= M_PROG;
               dly_r     <= `PROG_DLY;
               page_r    <= pg;
               tgt_r     <= c_addr;
               tgt_lck_r <= c_lock;
               tgt_dat_r <= c_dat;
               if (c_addr == 3'h0 && mk_frz)
                  tgt_dat_r[`CFG_MKEY_HI:`CFG_MKEY_LO] <= mkey;
            end else begin
               mode_r   <= M_BLK;
               page_r   <= pg;
               tx_blk_r <= c_addr;
            end
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mod_en_r    <= 1'b0;
         prog_busy_r <= 1'b0;
      end else begin
         mod_en_r    <= ((mode_r == M_REG) | (mode_r == M_BLK)) & ~frame
                        & (~(aor_en & pwd_en) | active_r);
         // start_r bridges the cycle between the delay and the sequencer
         prog_busy_r <= seq_busy | start_r | (dly_r != 4'h0);
      end
   end
endmodule

//--- cmd_decoder_chk.sv
`timescale 1ns/1ps
module cmd_decoder_chk #(
   parameter PROG_CLKS = 40
) (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        gap_in,
   input wire        tx_tick,
   input wire        nvm_fault,
   input wire        mod_en_r,
   input wire        tx_data_r,
   input wire        prog_busy_r
);
   localparam int PMIN = PROG_CLKS;
   localparam int PMAX = PROG_CLKS + 30;
   reg [15:0] blen_r;
   // length of the current busy stretch, judged when it ends
   always @(posedge pclk or negedge presetn)
      if (!presetn)
         blen_r <= 16'h0;
      else
         blen_r <= prog_busy_r ? blen_r + 16'h1 : 16'h0;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_setup_ack;
      psel && !penable |=> pready;
   endproperty
   a_setup_ack: assert property (p_setup_ack) else $error("no ready after setup");
   property p_ack_once;
      pready |=> !pready;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ready held too long");
   property p_ack_cause;
      $rose(pready) |-> $past(psel && !penable);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ready without setup");
   property p_err_zero;
      pslverr |-> pready && prdata == 32'h0;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("bad error response");
   property p_gap_mutes;
      $rose(gap_in) |-> ##[0:3] !mod_en_r;
   endproperty
   a_gap_mutes: assert property (p_gap_mutes) else $error("modulating in frame");
   property p_tx_on_tick;
      !$stable(tx_data_r) |-> $past(tx_tick);
   endproperty
   a_tx_on_tick: assert property (p_tx_on_tick) else $error("bit moved off tick");
   property p_prog_len;
      $fell(prog_busy_r) && !nvm_fault |-> blen_r >= PMIN && blen_r <= PMAX;
   endproperty
   a_prog_len: assert property (p_prog_len) else $error("program cycle length");
   property p_fault_mute;
      $fell(prog_busy_r) && nvm_fault |-> ##[0:4] !mod_en_r ##1 !mod_en_r;
   endproperty
   a_fault_mute: assert property (p_fault_mute) else $error("modulating after fault");
   cover property ($rose(prog_busy_r));
   cover property (pslverr);
   cover property ($fell(prog_busy_r) && nvm_fault);
endmodule
bind rfid_tag_command_decoder cmd_decoder_chk #(.PROG_CLKS(PROG_CLKS)) chk_u (
   .pclk        (pclk),
   .presetn     (presetn),
   .psel        (psel),
   .penable     (penable),
   .prdata      (prdata),
   .pready      (pready),
   .pslverr     (pslverr),
   .gap_in      (gap_in),
   .tx_tick     (tx_tick),
   .nvm_fault   (nvm_fault),
   .mod_en_r    (mod_en_r),
   .tx_data_r   (tx_data_r),
   .prog_busy_r (prog_busy_r)
);

//--- reader_model.sv
`timescale 1ns/1ps
module reader_model (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        req,
   input  wire [69:0] cmd,
   input  wire [6:0]  len,
   output reg         busy,
   output reg         fc_tick,
   output reg         gap_in
);
   reg     div_r;
   integer i;
   // the carrier never stops, so the field clock runs free
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r <= 1'b0;
         fc_tick <= 1'b0;
      end else begin
         div_r <= ~div_r;
         fc_tick <= div_r;
      end
   end
   task fcw(input integer n);
      begin
         repeat (n) begin
            @(posedge pclk);
            while (!fc_tick) @(posedge pclk);
         end
      end
   endtask
   // gap lasts 10 field clocks; intervals count gap start to gap start
   task gap;
      begin
         gap_in <= 1'b1;
         fcw(10);
         gap_in <= 1'b0;
      end
   endtask
   initial begin
      busy = 1'b0;
      gap_in = 1'b0;
      forever begin
         @(posedge pclk);
         if (req) begin
            busy <= 1'b1;
            gap;
            for (i = len - 1; i >= 0; i = i - 1) begin
               fcw(cmd[i] ? 44 : 14);
               gap;
            end
            fcw(70);
            busy <= 1'b0;
         end
      end
   end
endmodule

//--- tb_rfid_tag_command_decoder.sv
`timescale 1ns/1ps
module tb_rfid_tag_command_decoder;
   localparam [7:0] ST = 8'h04;
   localparam [7:0] LK = 8'h08;
   reg         pclk;
   reg         presetn;
   reg         psel;
   reg         penable;
   reg         pwrite;
   reg  [7:0]  paddr;
   reg  [31:0] pwdata;
   wire [31:0] prdata;
   wire        pready;
   wire        pslverr;
   wire        fc_tick;
   wire        gap_in;
   reg         tx_tick = 1'b0;
   reg         nvm_fault;
   wire        mod_en_r;
   wire        tx_data_r;
   wire        prog_busy_r;
   reg         req;
   reg  [69:0] cmd;
   reg  [6:0]  len;
   wire        busy;
   reg  [64:0] exp_q[$];
   reg  [64:0] e;
   integer     num_errors;
   integer     checks;
   integer     seed;
   reg  [31:0] d;
   reg  [31:0] pw;
   rfid_tag_command_decoder #(.PROG_CLKS(40), .POR_DLY_FC(20)) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fc_tick(fc_tick), .gap_in(gap_in), .tx_tick(tx_tick), .nvm_fault(nvm_fault),
      .mod_en_r(mod_en_r), .tx_data_r(tx_data_r), .prog_busy_r(prog_busy_r));
   reader_model rdr_u (
      .pclk(pclk), .presetn(presetn), .req(req), .cmd(cmd), .len(len),
      .busy(busy), .fc_tick(fc_tick), .gap_in(gap_in));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) tx_tick <= ~tx_tick;
   task apb(input w, input [7:0] a, input [31:0] v, input [31:0] m, input er);
      begin
         exp_q.push_back({er, m, v});
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= a;
         pwdata <= v;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (!pready) @(posedge pclk);
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   // returns once the frame and any programming it started are over
   task send(input [69:0] c, input [6:0] n);
      begin
         cmd <= c;
         len <= n;
         req <= 1'b1;
         @(posedge pclk);
         while (!busy) @(posedge pclk);
         req <= 1'b0;
         while (busy || prog_busy_r) @(posedge pclk);
      end
   endtask
   always @(posedge pclk) begin
      if (psel && penable && pready) begin
         e = exp_q.pop_front();
         checks = checks + 1;
         if (pslverr !== e[64] || (prdata & e[63:32]) !== (e[31:0] & e[63:32])) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED %0t apb read %h err %b", $time, prdata, pslverr);
         end
      end
   end
   task chk(input a, input b);
      begin
         checks = checks + 1;
         if (a !== b) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED %0t output level %b", $time, a);
         end
      end
   endtask
   task report_and_stop;
      begin
         $display("errors %0d checks %0d", num_errors, checks);
         if (num_errors == 0 && checks > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   initial begin
      repeat (100000) @(posedge pclk);
      num_errors = num_errors + 1;
      report_and_stop;
   end
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, nvm_fault, req, cmd, len} = 0;
      num_errors = 0;
      checks = 0;
      seed = 32'h59CD;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, ST, 32'h1, 32'h1F, 0);
      apb(0, LK, 32'h0, 32'hFF, 0);
      apb(0, 8'h10, 32'h0, ~32'h0, 1);
      repeat (440) @(posedge pclk);
      apb(0, ST, 32'h2, 32'h1F, 0);
      d = $random(seed);
      send({2'b10, 1'b1, d, 3'd3}, 7'd38);
      apb(0, 8'h2C, d, ~32'h0, 0);
      apb(0, LK, 32'h8, 32'hFF, 0);
      apb(0, ST, 32'h2604, 32'h7F1F, 0);
      send({2'b10, 1'b0, ~d, 3'd3}, 7'd38);
      apb(0, 8'h2C, d, ~32'h0, 0);
      apb(0, ST, 32'h4, 32'h1F, 0);
      send({2'b11, 1'b0, d, 2'd1}, 7'd37);
      apb(0, ST, 32'hA2, 32'hBF, 0);
      apb(1, ST, 32'h80, 0, 0);
      nvm_fault <= 1'b1;
      send({2'b10, 1'b0, d, 3'd4}, 7'd38);
      apb(0, ST, 32'h8010, 32'h809F, 0);
      chk(mod_en_r, 1'b0);
      nvm_fault <= 1'b0;
      send(70'h2, 7'd2);
      apb(0, ST, 32'h2, 32'h3F, 0);
      send({2'b11, 1'b0, 3'd3}, 7'd6);
      apb(0, ST, 32'h624, 32'h7F3F, 0);
      apb(1, 8'h20, 32'h60000000, 0, 0);
      send({2'b01, 1'b0, d, 3'd5}, 7'd38);
      apb(0, 8'h34, 32'h0, ~32'h0, 0);
      pw = $random(seed);
      apb(1, 8'h3C, pw, 0, 0);
      apb(1, 8'h20, 32'h210, 0, 0);
      send(70'h0, 7'd2);
      apb(0, ST, 32'h1, 32'h1F, 0);
      repeat (440) @(posedge pclk);
      apb(1, ST, 32'h80, 0, 0);
      apb(0, ST, 32'h0, 32'h40, 0);
      chk(mod_en_r, 1'b0);
      send({2'b10, pw}, 7'd34);
      apb(0, ST, 32'h40, 32'h40, 0);
      chk(mod_en_r, 1'b1);
      send({2'b10, ~pw, 1'b0, d, 3'd2}, 7'd70);
      apb(0, 8'h28, 32'h0, ~32'h0, 0);
      apb(0, ST, 32'h82, 32'hDF, 0);
      send({2'b10, pw}, 7'd34);
      send({2'b10, pw, 1'b0, d, 3'd2}, 7'd70);
      apb(0, 8'h28, d, ~32'h0, 0);
      report_and_stop;
   end
endmodule
